//--- core/zero_overhead_loop_pkg.sv
package zero_overhead_loop_pkg;

  // geometry
  localparam int unsigned ADDR_W      = 32;
  localparam int unsigned COUNT_W     = 32;
  localparam int unsigned NUM_LOOPS   = 2;
  localparam int unsigned BUS_ADDR_W  = 3;
  localparam int unsigned WORD_BYTES  = 4;

  // register word indexes on the slave port
  localparam logic [2:0] IDX_START0   = 3'h0;
  localparam logic [2:0] IDX_END0     = 3'h1;
  localparam logic [2:0] IDX_COUNT0   = 3'h2;
  localparam logic [2:0] IDX_START1   = 3'h3;
  localparam logic [2:0] IDX_END1     = 3'h4;
  localparam logic [2:0] IDX_COUNT1   = 3'h5;
  localparam logic [2:0] IDX_CONTROL  = 3'h6;
  localparam logic [2:0] IDX_STATUS   = 3'h7;

  // field positions
  localparam int unsigned CTRL_ENABLE_BIT  = 0;
  localparam int unsigned STAT_ACTIVE0_BIT = 0;
  localparam int unsigned STAT_ACTIVE1_BIT = 1;

  // reset values
  localparam logic [31:0] RESET_ADDR  = 32'h0000_0000;
  localparam logic [31:0] RESET_COUNT = 32'h0000_0000;
  localparam logic        RESET_ENABLE = 1'b1;

  // loop setup from decode: any subset of the three values of one set
  typedef struct packed {
    logic              valid;
    logic              loop_sel;
    logic              write_start;
    logic              write_end;
    logic              write_count;
    logic [31:0]       start_addr;
    logic [31:0]       end_addr;
    logic [31:0]       iter_count;
  } loop_setup_t;

  // one instruction leaving execute
  typedef struct packed {
    logic              valid;
    logic              killed;
    logic [31:0]       pc;
  } exec_info_t;

  // steering back to fetch
  typedef struct packed {
    logic              valid;
    logic [31:0]       target;
  } fetch_redirect_t;

endpackage

//--- core/hardware_loop_controller.sv
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - loop logic exists only when loop_feature_param is set, else constant zero.
// - iteration steers fetch to loop start with no stall and no branch penalty.
// - start register holds first body instruction address, the iteration target.
// - end register holds address after last body instruction; last sits at end-4.
// - counter decrements by one each time that loop's last instruction executes.
// - two independent register sets, each with start, end and counter.
// - all six values sit in separate flops, readable in register space.
// - when both loops match, loop 0 (inner) wins over loop 1 (outer).
// - a loop is active while its counter exceeds zero and redirects only while it exceeds one.
// - plain register writes to loop registers are refused and flag illegal instruction.
// - setup instruction updates start, end and counter of one set in one cycle.
// - interrupt on last instruction cancels it, saves its pc, leaves loop state.
module hardware_loop_controller #(
  parameter bit loop_feature_param = 1'b1
) (
  // clock and reset
  input  wire logic                                   clk,
  input  wire logic                                   rst,
  // loop setup instructions from decode
  input  wire zero_overhead_loop_pkg::loop_setup_t    setup,
  // instruction retiring from execute
  input  wire zero_overhead_loop_pkg::exec_info_t     exec_info,
  // fetch steering and exception side
  output var  zero_overhead_loop_pkg::fetch_redirect_t redirect,
  output logic                                        illegal_instr,
  output logic                                        cancel_valid,
  output logic [31:0]                                 cancel_epc,
  // avalon-mm slave
  input  wire logic [2:0]                             avs_address,
  input  wire logic                                   avs_read,
  input  wire logic                                   avs_write,
  input  wire logic [31:0]                            avs_writedata,
  input  wire logic [3:0]                             avs_byteenable,
  output logic [31:0]                                 avs_readdata,
  output logic                                        avs_waitrequest
);

  // refuse geometries that the two-set decode and word-wide registers cannot serve;
  // the checks sit at elaboration so a bad build never reaches simulation
  if (zero_overhead_loop_pkg::NUM_LOOPS != 2) begin : g_bad_loops
    $error("hardware_loop_controller serves exactly two loop sets");
  end
  if (zero_overhead_loop_pkg::ADDR_W != 32) begin : g_bad_addr
    $error("hardware_loop_controller needs 32-bit addresses");
  end
  if (zero_overhead_loop_pkg::COUNT_W != 32) begin : g_bad_count
    $error("hardware_loop_controller needs 32-bit loop counters");
  end
  if (zero_overhead_loop_pkg::WORD_BYTES != 4) begin : g_bad_word
    $error("hardware_loop_controller needs 4-byte instruction words");
  end
  if (zero_overhead_loop_pkg::BUS_ADDR_W != 3) begin : g_bad_bus
    $error("hardware_loop_controller decodes a 3-bit word index");
  end

  // whole unit state in one record: loop sets, enable, and every registered output;
  // keeping outputs in the record means each port comes straight from a flop

  typedef struct packed {
    logic [1:0][31:0] start_addr;
    logic [1:0][31:0] end_addr;
    logic [1:0][31:0] iter_count;
    logic             loop_on;
    logic             redir_valid;
    logic [31:0]      redir_target;
    logic             illegal;
    logic             cancel;
    logic [31:0]      epc;
    logic [31:0]      readdata;
    logic             waitreq;
  } state_t;

  state_t state;
  state_t next_state;

  // a set counts as active while it still owes passes
  function automatic logic set_active(input logic [31:0] count);
    set_active = (count != zero_overhead_loop_pkg::RESET_COUNT);
  endfunction

  // last body instruction of a set sits one word below its end address
  function automatic logic is_last(input logic [31:0] pc, input logic [31:0] end_addr,
                                   input logic [31:0] count);
    logic [31:0] last_pc;
    last_pc = end_addr - 32'(zero_overhead_loop_pkg::WORD_BYTES);
    is_last = set_active(count) && (pc == last_pc);
  endfunction

  // read mux, narrow byte enables ignored: every register is a whole word
  function automatic logic [31:0] read_word(input state_t s, input logic [2:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      zero_overhead_loop_pkg::IDX_START0:  w = s.start_addr[0];
      zero_overhead_loop_pkg::IDX_END0:    w = s.end_addr[0];
      zero_overhead_loop_pkg::IDX_COUNT0:  w = s.iter_count[0];
      zero_overhead_loop_pkg::IDX_START1:  w = s.start_addr[1];
      zero_overhead_loop_pkg::IDX_END1:    w = s.end_addr[1];
      zero_overhead_loop_pkg::IDX_COUNT1:  w = s.iter_count[1];
      zero_overhead_loop_pkg::IDX_CONTROL: w[zero_overhead_loop_pkg::CTRL_ENABLE_BIT] = s.loop_on;
      zero_overhead_loop_pkg::IDX_STATUS: begin
        w[zero_overhead_loop_pkg::STAT_ACTIVE0_BIT] = set_active(s.iter_count[0]);
        w[zero_overhead_loop_pkg::STAT_ACTIVE1_BIT] = set_active(s.iter_count[1]);
      end
      default: w = 32'h0000_0000;
    endcase
    read_word = w;
  endfunction

  // loop registers live at the six lowest word indexes; only setup may write them
  function automatic logic is_loop_reg(input logic [2:0] idx);
    logic hit;
    hit = 1'b0;
    case (idx)
      zero_overhead_loop_pkg::IDX_START0,
      zero_overhead_loop_pkg::IDX_END0,
      zero_overhead_loop_pkg::IDX_COUNT0,
      zero_overhead_loop_pkg::IDX_START1,
      zero_overhead_loop_pkg::IDX_END1,
      zero_overhead_loop_pkg::IDX_COUNT1: hit = 1'b1;
      default:                            hit = 1'b0;
    endcase
    is_loop_reg = hit;
  endfunction

  // a set still owes a pass back to its start while more than one pass remains
  function automatic logic wants_redirect(input logic [31:0] count);
    wants_redirect = (count != 32'h0000_0001);
  endfunction

  // one iteration consumed; callers only reach here with a nonzero count
  function automatic logic [31:0] count_down(input logic [31:0] count);
    count_down = count - 32'h0000_0001;
  endfunction

  // pick the set that owns a retiring last instruction, inner set first
  function automatic logic pick_set(input logic h0, input logic h1);
    pick_set = !h0 && h1;
  endfunction

  logic hit0;
  logic hit1;
  logic any_hit;
  logic hit_sel;
  logic retire;
  logic kill_hit;
  logic bus_req;
  logic take_bus;
  logic take_rd;
  logic take_wr;
  logic ctrl_wr;
  logic loop_reg_wr;

  // loop match on the retiring instruction; both sets are compared every cycle
  assign hit0    = is_last(exec_info.pc, state.end_addr[0], state.iter_count[0]);
  assign hit1    = is_last(exec_info.pc, state.end_addr[1], state.iter_count[1]);
  assign any_hit = hit0 || hit1;
  // when both sets match the same pc, set 0 owns it and set 1 keeps its count
  assign hit_sel = pick_set(hit0, hit1);

  // a killed instruction has not executed: loop state waits for its replay
  assign retire   = exec_info.valid && !exec_info.killed && state.loop_on;
  assign kill_hit = exec_info.valid && exec_info.killed && any_hit;

  // bus decode, taken only on the edge where waitrequest still stands high
  assign bus_req     = avs_read || avs_write;
  assign take_bus    = bus_req && state.waitreq;
  assign take_rd     = take_bus && avs_read;
  assign take_wr     = take_bus && avs_write;
  assign ctrl_wr     = take_wr && (avs_address == zero_overhead_loop_pkg::IDX_CONTROL);
  assign loop_reg_wr = take_wr && is_loop_reg(avs_address);

  // next state of the whole unit; later sections win over earlier ones:
  // pulses default low, then cancel, retire, setup, bus, and finally the
  // feature mask, so a build without loops cannot leak any loop effect
  always_comb begin
    next_state = state;
    next_state.redir_valid = 1'b0;
    next_state.illegal = 1'b0;
    next_state.cancel = 1'b0;

    // cancelled last instruction: report its pc so the return resumes on it
    if (kill_hit) begin
      next_state.cancel = 1'b1;
      next_state.epc = exec_info.pc;
    end

    // retiring last instruction: consume one pass of the owning set
    if (retire && any_hit) begin
      next_state.iter_count[hit_sel] = count_down(state.iter_count[hit_sel]);
      // target handed to fetch so the next fetch is the body head, no bubble
      if (wants_redirect(state.iter_count[hit_sel])) begin
        next_state.redir_valid = 1'b1;
        next_state.redir_target = state.start_addr[hit_sel];
      end
    end

    // setup with write_count overrides a same-cycle decrement of the same set;
    // all selected fields land on one edge, so a set never runs half-written
    if (setup.valid) begin
      if (setup.write_start) begin
        next_state.start_addr[setup.loop_sel] = setup.start_addr;
      end
      if (setup.write_end) begin
        next_state.end_addr[setup.loop_sel] = setup.end_addr;
      end
      if (setup.write_count) begin
        next_state.iter_count[setup.loop_sel] = setup.iter_count;
      end
    end

    // bus slave: one wait cycle, then answer for one cycle;
    // waitrequest drops only after a take, so a held request is never taken twice
    next_state.waitreq = !take_bus;
    if (take_rd) begin
      next_state.readdata = read_word(state, avs_address);
    end
    // only the enable bit is writable; status writes vanish without complaint
    if (ctrl_wr && avs_byteenable[0]) begin
      next_state.loop_on = avs_writedata[zero_overhead_loop_pkg::CTRL_ENABLE_BIT];
    end
    // loop registers belong to the setup path alone
    if (loop_reg_wr) begin
      next_state.illegal = 1'b1;
    end

    // without the feature the loop flops stay constant and fold away;
    // the bus still answers so software sees zeros, except the writable control enable bit, rather than a hang
    if (!loop_feature_param) begin
      next_state.start_addr = '0;
      next_state.end_addr = '0;
      next_state.iter_count = '0;
      next_state.redir_valid = 1'b0;
      next_state.cancel = 1'b0;
      next_state.illegal = 1'b0;
    end
  end

  // state register; reset loads constants only, counts at zero keep both sets idle
  // until setup, so no redirect can fire from stale addresses after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state.start_addr   <= {2{zero_overhead_loop_pkg::RESET_ADDR}};
      state.end_addr     <= {2{zero_overhead_loop_pkg::RESET_ADDR}};
      state.iter_count   <= {2{zero_overhead_loop_pkg::RESET_COUNT}};
      state.loop_on      <= zero_overhead_loop_pkg::RESET_ENABLE;
      state.redir_valid  <= 1'b0;
      state.redir_target <= zero_overhead_loop_pkg::RESET_ADDR;
      state.illegal      <= 1'b0;
      state.cancel       <= 1'b0;
      state.epc          <= zero_overhead_loop_pkg::RESET_ADDR;
      state.readdata     <= 32'h0000_0000;
      state.waitreq      <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from the state flops; fetch sees the redirect one cycle
  // after the last instruction, which the core folds into its next fetch
  assign redirect.valid  = state.redir_valid;
  assign redirect.target = state.redir_target;
  assign illegal_instr   = state.illegal;
  assign cancel_valid    = state.cancel;
  assign cancel_epc      = state.epc;
  assign avs_readdata    = state.readdata;
  assign avs_waitrequest = state.waitreq;

endmodule

`default_nettype wire

//--- dv/loop_ctrl_props.sv
`timescale 1ns/10ps
`default_nettype none
// port-level checks of the loop unit
module loop_ctrl_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched ports
  input wire zero_overhead_loop_pkg::exec_info_t      exec_info,
  input wire zero_overhead_loop_pkg::fetch_redirect_t redirect,
  input wire logic        illegal_instr,
  input wire logic        cancel_valid,
  input wire logic [31:0] cancel_epc,
  input wire logic [2:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // bus answers one cycle after taking, then idles high
  property p_ack; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("bus answer late");
  property p_ack_once; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_ack_once: assert property (p_ack_once) else $error("bus answer held");
  // plain writes to loop registers are refused
  property p_ill; avs_write && avs_waitrequest && avs_address <= 3'h5 |=> illegal_instr; endproperty
  a_ill: assert property (p_ill) else $error("refusal missing");
  property p_ill_why; illegal_instr |-> $past(avs_write && avs_address <= 3'h5); endproperty
  a_ill_why: assert property (p_ill_why) else $error("spurious refusal");
  // redirect only follows a retired instruction
  property p_redir_why; redirect.valid |-> $past(exec_info.valid && !exec_info.killed); endproperty
  a_redir_why: assert property (p_redir_why) else $error("spurious redirect");
  property p_kill_quiet; exec_info.valid && exec_info.killed |=> !redirect.valid; endproperty
  a_kill_quiet: assert property (p_kill_quiet) else $error("killed redirects");
  property p_cancel_why; cancel_valid |-> $past(exec_info.valid && exec_info.killed); endproperty
  a_cancel_why: assert property (p_cancel_why) else $error("spurious cancel");
  property p_cancel_pc; cancel_valid |-> cancel_epc == $past(exec_info.pc); endproperty
  a_cancel_pc: assert property (p_cancel_pc) else $error("wrong return pc");
  c_redir: cover property (redirect.valid);
  c_cancel: cover property (cancel_valid);
  c_ill: cover property (illegal_instr);
endmodule
bind hardware_loop_controller loop_ctrl_props u_props (
  .clk(clk), .rst(rst), .exec_info(exec_info), .redirect(redirect),
  .illegal_instr(illegal_instr), .cancel_valid(cancel_valid), .cancel_epc(cancel_epc),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest)
);
`default_nettype wire

//--- dv/core_model.sv
`timescale 1ns/10ps
`default_nettype none
// behavioural core: retires one instruction every third cycle
module core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench control
  input wire logic        run,
  input wire logic        kill,
  input wire logic [31:0] first_pc,
  // loop unit side
  input wire zero_overhead_loop_pkg::fetch_redirect_t redirect,
  output var zero_overhead_loop_pkg::exec_info_t      exec_info
);
  logic [1:0]  phase;
  logic [31:0] pc;
  // three phases so the registered redirect is seen before the next fetch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= 2'h0;
      pc <= 32'h0;
      exec_info <= '0;
    end else if (!run) begin
      phase <= 2'h0;
      pc <= first_pc;
      exec_info <= '0;
    end else begin
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      // pc inverted between instructions so a stale value never matches
      exec_info <= '{valid: phase == 2'h0, killed: kill, pc: (phase == 2'h0) ? pc : ~pc};
      if (phase == 2'h2) pc <= redirect.valid ? redirect.target : pc + 32'h4;
    end
  end
endmodule
`default_nettype wire

//--- dv/test_hardware_loop_controller.sv
`timescale 1ns/10ps
`default_nettype none
// directed checks of the loop unit beside a behavioural core
module test_hardware_loop_controller;
  logic clk, rst, run, kill, avs_read, avs_write, avs_waitrequest, illegal_instr, cancel_valid;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, cancel_epc, first_pc, q;
  zero_overhead_loop_pkg::loop_setup_t setup;
  zero_overhead_loop_pkg::exec_info_t exec_info;
  zero_overhead_loop_pkg::fetch_redirect_t redirect;
  int mismatches = 0, checks = 0, n_last = 0, n_redir = 0, n_cancel = 0, n_ill = 0;
  hardware_loop_controller u_dut (.clk(clk), .rst(rst), .setup(setup), .exec_info(exec_info),
    .redirect(redirect), .illegal_instr(illegal_instr), .cancel_valid(cancel_valid),
    .cancel_epc(cancel_epc), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  core_model u_core (.clk(clk), .rst(rst), .run(run), .kill(kill), .first_pc(first_pc),
    .redirect(redirect), .exec_info(exec_info));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // event counters; last body instruction sits at 0x18
  always @(posedge clk) begin
    if (exec_info.valid === 1'b1 && exec_info.pc === 32'h18) n_last++;
    if (redirect.valid === 1'b1) n_redir++;
    if (cancel_valid === 1'b1) n_cancel++;
    if (illegal_instr === 1'b1) n_ill++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one avalon transfer held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin @(posedge clk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      mismatches++;
      $display("BAD %0t bus answer missing", $time);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic do_setup(input logic sel, input logic [2:0] w, input logic [31:0] s, e, c);
    setup <= '{valid: 1'b1, loop_sel: sel, write_start: w[2], write_end: w[1],
      write_count: w[0], start_addr: s, end_addr: e, iter_count: c};
    @(posedge clk);
    setup <= '0;
    @(posedge clk);
  endtask
  task automatic run_to(input logic [31:0] p0, input logic [31:0] stop, input logic k);
    int n;
    first_pc <= p0;
    kill <= k;
    @(posedge clk);
    run <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end
      while (!(exec_info.valid === 1'b1 && exec_info.pc === stop) && n < 300);
    if (!(exec_info.valid === 1'b1 && exec_info.pc === stop)) begin
      mismatches++;
      $display("BAD %0t stop pc never reached", $time);
    end
    run <= 1'b0;
  endtask
  task automatic t_reset;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 3'(i), 32'h0);
      chk(q, (i == 6) ? 32'h1 : 32'h0);
    end
    $display("reset test done");
  endtask
  task automatic t_setup;
    logic [31:0] e [6];
    e = '{32'h10, 32'h1C, 32'h3, 32'h40, 32'h1C, 32'h2};
    do_setup(1'b0, 3'h7, 32'h10, 32'h1C, 32'h3);
    do_setup(1'b1, 3'h7, 32'h40, 32'h1C, 32'h2);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 3'(i), 32'h0);
      chk(q, e[i]);
    end
    bus(1'b0, zero_overhead_loop_pkg::IDX_STATUS, 32'h0);
    chk(q, 32'h3);
    $display("setup test done");
  endtask
  task automatic t_illegal;
    bus(1'b1, zero_overhead_loop_pkg::IDX_COUNT0, 32'h5);
    bus(1'b0, zero_overhead_loop_pkg::IDX_COUNT0, 32'h0);
    chk(q, 32'h3);
    chk(n_ill, 32'h1);
    $display("refusal test done");
  endtask
  // both loops end at 0x1C; inner must win and run three passes
  task automatic t_loop;
    run_to(32'h10, 32'h20, 1'b0);
    chk(n_last, 32'h3);
    chk(n_redir, 32'h2);
    bus(1'b0, zero_overhead_loop_pkg::IDX_COUNT0, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, zero_overhead_loop_pkg::IDX_COUNT1, 32'h0);
    chk(q, 32'h2);
    bus(1'b0, zero_overhead_loop_pkg::IDX_STATUS, 32'h0);
    chk(q, 32'h2);
    $display("loop test done");
  endtask
  // loop enable cleared: last instructions retire with no pass consumed
  task automatic t_disable;
    bus(1'b1, zero_overhead_loop_pkg::IDX_CONTROL, 32'h0);
    bus(1'b0, zero_overhead_loop_pkg::IDX_CONTROL, 32'h0);
    chk(q, 32'h0);
    do_setup(1'b0, 3'h1, 32'h0, 32'h0, 32'h2);
    n_redir = 0;
    run_to(32'h10, 32'h20, 1'b0);
    chk(n_redir, 32'h0);
    bus(1'b0, zero_overhead_loop_pkg::IDX_COUNT0, 32'h0);
    chk(q, 32'h2);
    bus(1'b1, zero_overhead_loop_pkg::IDX_CONTROL, 32'h1);
    bus(1'b0, zero_overhead_loop_pkg::IDX_CONTROL, 32'h0);
    chk(q, 32'h1);
    chk(n_ill, 32'h1);
    $display("enable test done");
  endtask
  // every instruction cancelled: count only reloaded, nothing retires
  task automatic t_kill;
    do_setup(1'b0, 3'h1, 32'h0, 32'h0, 32'h2);
    n_redir = 0;
    run_to(32'h10, 32'h20, 1'b1);
    chk(n_cancel, 32'h1);
    chk(cancel_epc, 32'h18);
    chk(n_redir, 32'h0);
    bus(1'b0, zero_overhead_loop_pkg::IDX_COUNT0, 32'h0);
    chk(q, 32'h2);
    $display("cancel test done");
  endtask
  initial begin
    rst = 1'b1;
    run = 1'b0;
    kill = 1'b0;
    first_pc = 32'h0;
    setup = '0;
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_setup();
    t_illegal();
    t_loop();
    t_disable();
    t_kill();
    stop_test();
  end
  // watchdog well beyond the fewer than two hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire
